// file: logic/dscd_decoder.sv
// Instruction format, operand-class and cycle-count decoder with status
// flags, reached over AHB-Lite. Assumes one program word per hclk under
// pm_valid, a datapath that samples dec on dec_valid, and one bus master.
//
// Overview of operation
// - Each single word is 24 bits; 8-bit opcode picks type, rest operands.
// - Exactly three instructions take two program words; others one.
// - Two-word instructions carry 48 bits; second word top 8 bits zero.
// - A second word executed alone performs no operation.
// - Every two-word instruction completes in two cycles.
// - Single word takes one cycle, two if condition true or PC changes.
// - Branch, indirect call/jump, table access, returns take two or three.
// - Taken skip takes two cycles, three over a two-word instruction.
// - Working-register class decodes base, source and destination operands.
// - File class decodes file address and file-or-register-zero select.
// - Bit class uses register or file operand; bit by literal or base.
// - Literal class decodes base, literal, destination if different.
// - Multiply class: accumulator, multiplicands, prefetches, write-back.
// - Other DSP decodes accumulator, operand with modifier, shift amount.
// - Write-back: register thirteen, or its target then plus two.
// - File address reaches data addresses zero through the upper limit.
// - Ten-bit literal limited to 255 in byte mode, 1023 in word.
// - Program address literal always has its least significant bit zero.
// - Five flags: carry, digit carry, negative, overflow, sticky zero.
// - Four DSP flags: overflow and saturation of accumulators A and B.
// - Four-bit bit select chooses one of sixteen operand bit positions.
// - Word mode unless byte or double selected; shadow select decodable.
`include "dscd_cfg.svh"
module dscd_decoder (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Program memory side
    input  wire logic                   pm_valid,
    input  wire logic [23:0]            pm_word,
    input  wire logic [23:0]            pm_next_word,
    // Execution side
    input  wire logic                   exec_cond_true,
    input  wire dscd_pkg::dscd_flag_upd_t exec_flags,
    output dscd_pkg::dscd_dec_t         dec,
    output logic                        dec_valid,
    output logic      [8:0]             status_flags
);
    import dscd_pkg::*;

    dscd_st_t    st_r, st_nxt;
    dscd_dec_t   dec_r, dec_nxt, hold_r, hold_nxt, d;
    dscd_cls_t   cls;
    logic        dvld_r, dvld_nxt;
    logic [31:0] ctrl_r, ctrl_nxt, cyc_r, cyc_nxt, rdata_r, rdata_nxt;
    logic [23:0] last_r, last_nxt;
    logic [8:0]  flg_r, flg_nxt;
    logic [2:0]  err_r, err_nxt, err_set;
    logic [7:0]  aofs_r, aofs_nxt;
    logic        wr_r, wr_nxt, ap, two, lit_err;
    logic [7:0]  op;

    // Two-word opcodes
    function automatic logic is_two(input logic [7:0] o);
        is_two = (o == `DSCD_OP_GOTO2) || (o == `DSCD_OP_CALL2) ||
                 (o == `DSCD_OP_MOVD2);
    endfunction

    // Operand class from the class nibble
    always_comb begin
        case (pm_word[`DSCD_F_CLS])
            `DSCD_CN_CTRL: cls = DSCD_CLS_CTRL;
            `DSCD_CN_FILE: cls = DSCD_CLS_FILE;
            `DSCD_CN_BIT:  cls = DSCD_CLS_BIT;
            `DSCD_CN_MAC:  cls = DSCD_CLS_MAC;
            `DSCD_CN_DSP:  cls = DSCD_CLS_DSP;
            `DSCD_CN_LITA: cls = DSCD_CLS_LIT;
            `DSCD_CN_LITB: cls = DSCD_CLS_LIT;
            default: begin
                cls = pm_word[`DSCD_B_WCLS + 20] ? DSCD_CLS_WORKING_REG_ZERO
                                                 : DSCD_CLS_RSVD;
            end
        endcase
    end

    // First-word decode of operands, mode and cycle count
    always_comb begin
        op = pm_word[`DSCD_F_OPC];
        d = '0;
        d.cls = cls;
        d.opcode = op;
        d.cycles = `DSCD_CYC_ONE;
        lit_err = 1'b0;
        two = 1'b0;
        case (cls)
            DSCD_CLS_CTRL: begin
                d.shadow = pm_word[`DSCD_B_SHADOW];
                if (op == `DSCD_OP_NOP) begin
                    d.nop = 1'b1;
                end else if (op == `DSCD_OP_CBRA) begin
                    d.cycles = exec_cond_true ? `DSCD_CYC_TWO
                                              : `DSCD_CYC_ONE;
                end else if (op == `DSCD_OP_SKIP) begin
                    if (exec_cond_true) begin
                        d.cycles = is_two(pm_next_word[`DSCD_F_OPC]) ?
                            `DSCD_CYC_THREE : `DSCD_CYC_TWO;
                    end
                end else if (op == `DSCD_OP_JMP || op == `DSCD_OP_CALLI ||
                             op == `DSCD_OP_GOTOI || op == `DSCD_OP_TBLRD ||
                             op == `DSCD_OP_TBLWR) begin
                    d.cycles = `DSCD_CYC_TWO;
                end else if (op == `DSCD_OP_RET || op == `DSCD_OP_RETI) begin
                    d.cycles = `DSCD_CYC_THREE;
                end else if (is_two(op)) begin
                    two = 1'b1;
                    d.shadow = 1'b0;
                    d.two_word = 1'b1;
                    d.cycles = `DSCD_CYC_TWO;
                    d.program_addr_literal =
                        23'(pm_word[`DSCD_F_PALO]);
                end else begin
                    d.nop = 1'b1;
                end
            end
            DSCD_CLS_FILE: begin
                d.file_addr = pm_word[`DSCD_F_FADDR];
                d.to_working_reg_zero = !pm_word[`DSCD_B_TOFILE];
                d.flag_mask = `DSCD_FLG_GEN;
            end
            DSCD_CLS_BIT: begin
                d.bit_position_field = pm_word[`DSCD_F_BSEL];
                d.bit_mask = `DSCD_BIT0 << pm_word[`DSCD_F_BSEL];
                d.bit_indirect = pm_word[`DSCD_B_BITIND];
                if (pm_word[`DSCD_B_BITFILE]) begin
                    d.file_addr = 13'(pm_word[`DSCD_F_BFADDR]);
                end else begin
                    d.src_mode = pm_word[`DSCD_F_SMODE];
                    d.source_work_reg = pm_word[`DSCD_F_SREG];
                end
                d.base_work_reg = pm_word[`DSCD_F_BW];
                d.flag_mask = `DSCD_FLG_GEN;
            end
            DSCD_CLS_LIT: begin
                d.base_work_reg = pm_word[`DSCD_F_BW];
                d.dest_work_reg = pm_word[`DSCD_F_LDST];
                d.dst_present = pm_word[`DSCD_F_LDST] !=
                                pm_word[`DSCD_F_BW];
                d.ten_bit_literal = pm_word[`DSCD_F_LITX];
                if (pm_word[`DSCD_B_BYTE]) begin
                    d.mode = DSCD_MODE_BYTE;
                    lit_err = pm_word[`DSCD_F_LITX] > `DSCD_LIT_BYTE;
                    d.ten_bit_literal = pm_word[`DSCD_F_LITX] &
                                        `DSCD_LIT_BYTE;
                end
                d.flag_mask = `DSCD_FLG_GEN;
            end
            DSCD_CLS_MAC: begin
                d.acc_b = pm_word[`DSCD_B_ACC];
                d.mul_pair = pm_word[`DSCD_F_MUL];
                d.x_prefetch = pm_word[`DSCD_F_XPF];
                d.x_dest = pm_word[`DSCD_F_XD];
                d.y_prefetch = pm_word[`DSCD_F_YPF];
                d.y_dest = pm_word[`DSCD_F_YD];
                case (pm_word[`DSCD_F_WBK])
                    2'h1:    d.accum_writeback_dest = DSCD_WBK_W13;
                    2'h2:    d.accum_writeback_dest = DSCD_WBK_INC2;
                    default: d.accum_writeback_dest = DSCD_WBK_NONE;
                endcase
                d.flag_mask = `DSCD_FLG_DSP;
            end
            DSCD_CLS_DSP: begin
                d.acc_b = pm_word[`DSCD_B_ACC];
                d.shift_literal = pm_word[`DSCD_B_SHLIT];
                d.shift_amount = pm_word[`DSCD_F_SHAMT];
                d.src_mode = pm_word[`DSCD_F_SMODE];
                d.source_work_reg = pm_word[`DSCD_F_SREG];
                d.flag_mask = `DSCD_FLG_DSP;
            end
            DSCD_CLS_WORKING_REG_ZERO: begin
                d.base_work_reg = pm_word[`DSCD_F_BW];
                d.src_mode = pm_word[`DSCD_F_SMODE];
                d.source_work_reg = pm_word[`DSCD_F_SREG];
                d.dst_mode = pm_word[`DSCD_F_DMODE];
                d.dest_work_reg = pm_word[`DSCD_F_DREG];
                d.dst_present = 1'b1;
                d.flag_mask = `DSCD_FLG_GEN;
            end
            default: d.nop = 1'b1;
        endcase
        // Width mode for data classes
        if (cls == DSCD_CLS_FILE || cls == DSCD_CLS_WORKING_REG_ZERO) begin
            if (pm_word[`DSCD_B_DWORD]) begin
                d.mode = DSCD_MODE_DWORD;
            end else if (pm_word[`DSCD_B_BYTE]) begin
                d.mode = DSCD_MODE_BYTE;
            end
        end
    end

    // Sequencing of first and second words
    always_comb begin
        st_nxt = st_r;
        hold_nxt = hold_r;
        dec_nxt = dec_r;
        dvld_nxt = 1'b0;
        last_nxt = last_r;
        err_set = '0;
        case (st_r)
            DSCD_ST_FIRST: begin
                if (pm_valid) begin
                    last_nxt = pm_word;
                    if (!ctrl_r[`DSCD_B_EN]) begin
                        dec_nxt = '0;
                        dec_nxt.nop = 1'b1;
                        dec_nxt.cls = DSCD_CLS_RSVD;
                        dec_nxt.cycles = `DSCD_CYC_ONE;
                        dvld_nxt = 1'b1;
                    end else if (two) begin
                        hold_nxt = d;
                        st_nxt = DSCD_ST_SECOND;
                    end else begin
                        dec_nxt = d;
                        dvld_nxt = 1'b1;
                        err_set[`DSCD_E_LIT] = lit_err;
                    end
                end
            end
            DSCD_ST_SECOND: begin
                if (pm_valid) begin
                    dec_nxt = hold_r;
                    dec_nxt.program_addr_literal = {pm_word[`DSCD_F_PAHI],
                        hold_r.program_addr_literal[15:1], 1'b0};
                    err_set[`DSCD_E_ODD] = hold_r.program_addr_literal[0];
                    err_set[`DSCD_E_W2] =
                        pm_word[`DSCD_F_W2TOP] != `DSCD_W2_ZERO;
                    dvld_nxt = 1'b1;
                    st_nxt = DSCD_ST_FIRST;
                end
            end
            default: st_nxt = DSCD_ST_FIRST;
        endcase
    end

    // Decoder state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= DSCD_ST_FIRST;
            hold_r <= '0;
            dec_r <= '0;
            dvld_r <= 1'b0;
            last_r <= '0;
        end else begin
            st_r <= st_nxt;
            hold_r <= hold_nxt;
            dec_r <= dec_nxt;
            dvld_r <= dvld_nxt;
            last_r <= last_nxt;
        end
    end

    // Bus address phase capture and register writes
    always_comb begin
        ap = hsel && hready && htrans[`DSCD_B_HTACT];
        aofs_nxt = ap ? haddr[`DSCD_F_AOFS] : aofs_r;
        wr_nxt = ap && hwrite;
        rdata_nxt = rdata_r;
        if (ap && !hwrite) begin
            case (haddr[`DSCD_F_AOFS])
                `DSCD_A_CTRL: rdata_nxt = ctrl_r;
                `DSCD_A_STAT: rdata_nxt = 32'(flg_r);
                `DSCD_A_ERR:  rdata_nxt = 32'(err_r);
                `DSCD_A_LAST: rdata_nxt = 32'(last_r);
                `DSCD_A_CYC:  rdata_nxt = cyc_r;
                default:      rdata_nxt = `DSCD_ZERO32;
            endcase
        end
        ctrl_nxt = ctrl_r;
        if (wr_r && aofs_r == `DSCD_A_CTRL) begin
            ctrl_nxt = hwdata;
        end
        // Error flags: write one to clear, a new event wins
        err_nxt = err_r;
        if (wr_r && aofs_r == `DSCD_A_ERR) begin
            err_nxt = err_r & ~hwdata[2:0];
        end
        err_nxt = err_nxt | err_set;
        // Status flags: datapath update wins over a software write
        flg_nxt = flg_r;
        if (wr_r && aofs_r == `DSCD_A_STAT) begin
            flg_nxt = hwdata[8:0];
        end
        for (int i = 0; i < 9; i++) begin
            if (exec_flags.upd[i]) begin
                flg_nxt[i] = (i == `DSCD_FLG_Z) ?
                    (flg_r[i] & exec_flags.val[i]) :
                    exec_flags.val[i];
            end
        end
        cyc_nxt = dvld_r ? cyc_r + 32'(dec_r.cycles) : cyc_r;
    end

    // Bus and software-visible registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aofs_r <= '0;
            wr_r <= 1'b0;
            rdata_r <= `DSCD_ZERO32;
            ctrl_r <= `DSCD_CTRL_RST;
            err_r <= '0;
            flg_r <= '0;
            cyc_r <= `DSCD_ZERO32;
        end else begin
            aofs_r <= aofs_nxt;
            wr_r <= wr_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            err_r <= err_nxt;
            flg_r <= flg_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    // Outputs straight from registers; hreadyout and hresp tied to constants
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = `DSCD_HRESP_OK;
    assign dec = dec_r;
    assign dec_valid = dvld_r;
    assign status_flags = flg_r;

endmodule

// file: include/dscd_cfg.svh
// Field positions, opcodes, cycle counts and register map.
// Definitions only; included by the decoder.
`ifndef DSCD_CFG_SVH
`define DSCD_CFG_SVH

// Program word fields
`define DSCD_F_OPC      23:16
`define DSCD_F_CLS      23:20
`define DSCD_F_BW       19:16
`define DSCD_F_WBK      17:16
`define DSCD_F_W2TOP    23:16
`define DSCD_B_DWORD    15
`define DSCD_B_BYTE     14
`define DSCD_F_DMODE    13:11
`define DSCD_F_DREG     10:7
`define DSCD_F_SMODE    6:4
`define DSCD_F_SREG     3:0
`define DSCD_B_TOFILE   13
`define DSCD_F_FADDR    12:0
`define DSCD_F_LITX     13:4
`define DSCD_F_LDST     3:0
`define DSCD_F_BSEL     15:12
`define DSCD_B_BITIND   11
`define DSCD_B_BITFILE  10
`define DSCD_F_BFADDR   9:0
`define DSCD_B_ACC      15
`define DSCD_F_MUL      14:12
`define DSCD_F_XPF      11:8
`define DSCD_F_XD       7:6
`define DSCD_F_YPF      5:2
`define DSCD_F_YD       1:0
`define DSCD_B_SHLIT    14
`define DSCD_F_SHAMT    13:8
`define DSCD_B_SHADOW   15
`define DSCD_F_PALO     15:0
`define DSCD_F_PAHI     6:0

// Class nibbles
`define DSCD_CN_CTRL    4'h0
`define DSCD_CN_FILE    4'h1
`define DSCD_CN_BIT     4'h2
`define DSCD_CN_MAC     4'h3
`define DSCD_CN_DSP     4'h4
`define DSCD_CN_LITA    4'h6
`define DSCD_CN_LITB    4'h7
`define DSCD_B_WCLS     3

// Control opcodes
`define DSCD_OP_NOP     8'h00
`define DSCD_OP_JMP     8'h01
`define DSCD_OP_CBRA    8'h02
`define DSCD_OP_CALLI   8'h03
`define DSCD_OP_GOTOI   8'h04
`define DSCD_OP_TBLRD   8'h05
`define DSCD_OP_TBLWR   8'h06
`define DSCD_OP_RET     8'h07
`define DSCD_OP_RETI    8'h08
`define DSCD_OP_SKIP    8'h09
`define DSCD_OP_GOTO2   8'h0A
`define DSCD_OP_CALL2   8'h0B
`define DSCD_OP_MOVD2   8'h0C

// Cycle counts
`define DSCD_CYC_ONE    2'h1
`define DSCD_CYC_TWO    2'h2
`define DSCD_CYC_THREE  2'h3

// Flags and literal limits
`define DSCD_FLG_GEN    9'h01F
`define DSCD_FLG_DSP    9'h1E0
`define DSCD_FLG_Z      4
`define DSCD_LIT_BYTE   10'h0FF
`define DSCD_BIT0       16'h0001
`define DSCD_W2_ZERO    8'h00

// Register map and bits
`define DSCD_F_AOFS     7:0
`define DSCD_A_CTRL     8'h00
`define DSCD_A_STAT     8'h04
`define DSCD_A_ERR      8'h08
`define DSCD_A_LAST     8'h0C
`define DSCD_A_CYC      8'h10
`define DSCD_CTRL_RST   32'h0000_0001
`define DSCD_B_EN       0
`define DSCD_E_W2       0
`define DSCD_E_ODD      1
`define DSCD_E_LIT      2
`define DSCD_B_HTACT    1
`define DSCD_HRESP_OK   1'b0
`define DSCD_ZERO32     32'h0000_0000

`endif

// file: include/dscd_pkg.sv
// Types of the decoder and its bench: classes, modes, states, record.
// Needs no other file.
package dscd_pkg;
    typedef enum logic [2:0] {
        DSCD_CLS_CTRL = 3'h0, DSCD_CLS_FILE = 3'h1, DSCD_CLS_BIT = 3'h2,
        DSCD_CLS_LIT  = 3'h3, DSCD_CLS_MAC  = 3'h4, DSCD_CLS_DSP = 3'h5,
        DSCD_CLS_WORKING_REG_ZERO = 3'h6, DSCD_CLS_RSVD = 3'h7
    } dscd_cls_t;
    typedef enum logic [1:0] {
        DSCD_MODE_WORD = 2'h0, DSCD_MODE_BYTE = 2'h1, DSCD_MODE_DWORD = 2'h2
    } dscd_mode_t;
    typedef enum logic [1:0] {
        DSCD_WBK_NONE = 2'h0, DSCD_WBK_W13 = 2'h1, DSCD_WBK_INC2 = 2'h2
    } dscd_wbk_t;
    typedef enum logic [1:0] {
        DSCD_ST_FIRST = 2'h1, DSCD_ST_SECOND = 2'h2
    } dscd_st_t;
    typedef struct packed {
        logic [8:0] upd;
        logic [8:0] val;
    } dscd_flag_upd_t;
    typedef struct packed {
        dscd_cls_t  cls;
        logic [7:0] opcode;
        logic [1:0] cycles;
        logic       two_word;
        logic       nop;
        dscd_mode_t mode;
        logic       shadow;
        logic [3:0] base_work_reg;
        logic [2:0] src_mode;
        logic [3:0] source_work_reg;
        logic [2:0] dst_mode;
        logic [3:0] dest_work_reg;
        logic       dst_present;
        logic [12:0] file_addr;
        logic       to_working_reg_zero;
        logic [9:0] ten_bit_literal;
        logic [3:0] bit_position_field;
        logic [15:0] bit_mask;
        logic       bit_indirect;
        logic       acc_b;
        logic [2:0] mul_pair;
        logic [3:0] x_prefetch;
        logic [1:0] x_dest;
        logic [3:0] y_prefetch;
        logic [1:0] y_dest;
        dscd_wbk_t  accum_writeback_dest;
        logic       shift_literal;
        logic [5:0] shift_amount;
        logic [22:0] program_addr_literal;
        logic [8:0] flag_mask;
    } dscd_dec_t;
endpackage

// file: verification/dscd_assertions.sv
// Decoder checker: pairing, cycles, fields and flags.
// Sees only the decoder's own ports.
module dscd_assertions (
    // Clock and reset
    input wire logic                     hclk,
    input wire logic                     hresetn,
    // Decode stream
    input wire logic                     pm_valid,
    input wire dscd_pkg::dscd_flag_upd_t exec_flags,
    input wire dscd_pkg::dscd_dec_t      dec,
    input wire logic                     dec_valid,
    input wire logic [8:0]               status_flags
);
    import dscd_pkg::*;
    // One clock domain
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Result pulse follows a taken program word
    a_dec_follows_word:
    assert property (dec_valid |-> $past(pm_valid))
        else $error("pulse without word");
    a_two_word_set:
    assert property (dec_valid && dec.cls == DSCD_CLS_CTRL |->
        dec.two_word == (dec.opcode inside {8'h0A, 8'h0B, 8'h0C}))
        else $error("two-word marking wrong");
    a_two_word_span:
    assert property (dec_valid && dec.two_word |-> $past(pm_valid, 2))
        else $error("two-word span");
    a_two_word_cycles:
    assert property (dec_valid && dec.two_word |-> dec.cycles == 2'h2)
        else $error("two-word cycles");
    a_cycle_one:
    assert property (dec_valid && dec.cls != DSCD_CLS_CTRL |->
        dec.cycles == 2'h1)
        else $error("not one cycle");
    a_prog_addr_even:
    assert property (dec_valid |-> dec.program_addr_literal[0] == 1'b0)
        else $error("odd program address");
    a_byte_literal:
    assert property (dec_valid && dec.cls == DSCD_CLS_LIT &&
        dec.mode == DSCD_MODE_BYTE |-> dec.ten_bit_literal <= 10'h0FF)
        else $error("byte literal high");
    a_bit_mask:
    assert property (dec_valid && dec.cls == DSCD_CLS_BIT |->
        dec.bit_mask == (16'h0001 << dec.bit_position_field))
        else $error("bit mask wrong");
    a_wbk_select:
    assert property (dec_valid && dec.cls == DSCD_CLS_MAC |->
        dec.accum_writeback_dest == (dec.opcode[1:0] == 2'h1 ? DSCD_WBK_W13
        : dec.opcode[1:0] == 2'h2 ? DSCD_WBK_INC2 : DSCD_WBK_NONE))
        else $error("write-back wrong");
    a_flag_follow:
    assert property (|exec_flags.upd |=> ((status_flags ^
        $past(exec_flags.val)) & $past(exec_flags.upd) & 9'h1EF) == 9'h000)
        else $error("flag update lost");
    a_zero_sticky:
    assert property (exec_flags.upd[4] && !exec_flags.val[4] |=>
        !status_flags[4])
        else $error("zero not sticky");
endmodule

bind dscd_decoder dscd_assertions dscd_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .pm_valid(pm_valid),
    .exec_flags(exec_flags), .dec(dec), .dec_valid(dec_valid),
    .status_flags(status_flags));

// file: verification/tb.sv
// Bench: AHB-Lite tasks, a program word task, a table of control words.
// Assumes hreadyout is fed back as hready.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dscd_pkg::*;
    localparam logic [15:0] CTAB [12] = '{16'h1000, 16'h2001, 16'h1002,
        16'h2102, 16'h2003, 16'h2004, 16'h2005, 16'h2006, 16'h3008,
        16'h1009, 16'h2109, 16'h3309};
    logic           hclk = 1'b0;
    logic           hresetn = 1'b0;
    logic           hsel = 1'b0;
    logic [31:0]    haddr = 32'h0000_0000;
    logic [1:0]     htrans = 2'h0;
    logic           hwrite = 1'b0;
    logic [31:0]    hwdata = 32'h0000_0000;
    logic [31:0]    hrdata;
    logic           hready;
    logic           hresp;
    logic           pm_valid = 1'b0;
    logic [23:0]    pm_word = 24'h00_0000;
    logic [23:0]    pm_next_word = 24'h00_0000;
    logic           exec_cond_true = 1'b0;
    dscd_flag_upd_t exec_flags = '0;
    dscd_dec_t      dec;
    logic           dec_valid;
    logic [8:0]     status_flags;
    logic [31:0]    rd;
    logic [15:0]    ent;
    logic [23:0]    w1, w2;
    int             fails = 0;
    int             samples_checked = 0;
    int             cycle_cnt = 0;
    int             cyc_sum = 0;

    dscd_decoder dscd_decoder_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .pm_valid(pm_valid),
        .pm_word(pm_word), .pm_next_word(pm_next_word),
        .exec_cond_true(exec_cond_true), .exec_flags(exec_flags),
        .dec(dec), .dec_valid(dec_valid), .status_flags(status_flags));

    // Clock and hang guard
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 3000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One AHB-Lite word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a, wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check("hresp", hresp, 1'b0);
    endtask

    // One instruction of one or two words; ec 0 skips the count
    task automatic issue(input logic [23:0] a, b, nx, input logic cnd, two,
                         input logic [1:0] ec);
        @(posedge hclk);
        pm_valid <= 1'b1;
        pm_word <= a;
        pm_next_word <= nx;
        exec_cond_true <= cnd;
        if (two) begin
            @(posedge hclk);
            pm_word <= b;
            #1;
            check("dv_early", dec_valid, 1'b0);
        end
        @(posedge hclk);
        pm_valid <= 1'b0;
        #1;
        check("dec_valid", dec_valid, 1'b1);
        if (ec != 2'h0) check("cycles", dec.cycles, ec);
        cyc_sum += ec;
    endtask

    task automatic one(input logic [23:0] a);
        issue(a, 24'h00_0000, 24'h00_0000, 1'b0, 1'b0, 2'h1);
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, unmapped 0x14 last
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, i * 4, 32'h0000_0000);
            check("reg_reset", rd, (i == 0));
        end
        $display("test reset done");
        // Control words: cycles, lookahead, condition, opcode
        foreach (CTAB[i]) begin
            ent = CTAB[i];
            w1 = {ent[7:0], 16'h0000};
            issue(w1, 24'h00_0000, ent[9] ? 24'h0A_0000 : 24'h00_0000,
                  ent[8], 1'b0, ent[13:12]);
        end
        one(24'h00_4567);
        check("lone_second", dec.nop, 1'b1);
        for (int i = 0; i < 3; i++) begin
            w1 = {8'h0A + i[7:0], 16'h1235};
            w2 = {(i == 1) ? 8'h11 : 8'h00, 16'h0045};
            issue(w1, w2, 24'h00_0000, 1'b0, 1'b1, 2'h2);
            check("two_word", dec.two_word, 1'b1);
            if (i < 2) check("paddr", dec.program_addr_literal,
                             {w2[6:0], w1[15:1], 1'b0});
        end
        bus(1'b0, 32'h0000_000C, 32'h0000_0000);
        check("last", rd, 32'h000C_1235);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        check("err", rd, 32'h0000_0003);
        bus(1'b1, 32'h0000_0008, 32'h0000_0003);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        check("cyc_sum", rd, cyc_sum);
        issue(24'h07_0000, 24'h00_0000, 24'h00_0000, 1'b0, 1'b0, 2'h0);
        check("ret", dec.cycles inside {2'h2, 2'h3}, 1'b1);
        $display("test cycles done");
        // Operand fields of each class except control
        one(24'h85_5513);
        check("w_base", dec.base_work_reg, 4'h5);
        check("w_s", {dec.src_mode, dec.source_work_reg}, 7'h13);
        check("w_dst", {dec.dst_mode, dec.dest_work_reg}, 7'h2A);
        check("w_mode", dec.mode, DSCD_MODE_BYTE);
        one(24'h8F_8000);
        check("d_mode", dec.mode, DSCD_MODE_DWORD);
        one(24'h10_3ABC);
        check("f_addr", dec.file_addr, 13'h1ABC);
        check("f_wrz", dec.to_working_reg_zero, 1'b0);
        one(24'h10_1FFF);
        check("f_top", dec.file_addr, 13'h1FFF);
        check("f_wrz1", dec.to_working_reg_zero, 1'b1);
        one(24'h63_7FF3);
        check("l_cls", dec.cls, DSCD_CLS_LIT);
        check("l_byte", dec.ten_bit_literal, 10'h0FF);
        check("l_nodst", dec.dst_present, 1'b0);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        check("err_lit", rd, 32'h0000_0004);
        one(24'h63_3FF5);
        check("l_word", dec.ten_bit_literal, 10'h3FF);
        check("l_dst", dec.dst_present, 1'b1);
        one(24'h20_B000);
        check("b_mask", dec.bit_mask, 16'h0800);
        one(24'h20_0C00);
        check("b_ind", dec.bit_indirect, 1'b1);
        one(24'h32_5A5B);
        check("m_mul", dec.mul_pair, 3'h5);
        check("m_xy", {dec.x_prefetch, dec.y_prefetch}, 8'hA6);
        check("m_dst", {dec.x_dest, dec.y_dest}, 4'h7);
        check("m_wbk", dec.accum_writeback_dest, DSCD_WBK_INC2);
        one(24'h31_8000);
        check("m_acc", dec.acc_b, 1'b1);
        check("m_w13", dec.accum_writeback_dest, DSCD_WBK_W13);
        one(24'h40_D500);
        check("s_cls", dec.cls, DSCD_CLS_DSP);
        check("s_acc", dec.acc_b, 1'b1);
        check("s_lit", dec.shift_literal, 1'b1);
        check("s_amt", dec.shift_amount, 6'h15);
        $display("test fields done");
        // Software sets flags; datapath clears, zero stays sticky
        bus(1'b1, 32'h0000_0004, 32'h0000_01FF);
        exec_flags <= {9'h1FF, 9'h0A5};
        @(posedge hclk);
        exec_flags <= {9'h010, 9'h010};
        @(posedge hclk);
        exec_flags <= '0;
        bus(1'b0, 32'h0000_0004, 32'h0000_0000);
        check("flags", rd, 9'h0A5);
        check("flag_port", status_flags, 9'h0A5);
        // Disabled decoder gives plain records
        bus(1'b1, 32'h0000_0000, 32'h0000_0000);
        one(24'h01_0000);
        check("off_cls", dec.cls, DSCD_CLS_RSVD);
        $display("test flags and enable done");
        conclude();
    end
endmodule
